/* include/pwh_regs.vh */
// Register offsets, field positions and reset values of the parallel word port
// Assumes a plain register port with 3-bit word address and 16-bit data
// Function
// - Data ready from the far device sets the input flag.
// - Data ready with input interrupt enable set requests a host interrupt.
// - Acknowledged input interrupt clears input interrupt enable; software must set it again.
// - Input interrupt enable is status bit 6; writing 000100 octal sets it.
// - Writing 000100 octal to status sets input enable and clears input flag.
// - Host read of the input register pulses host_took_input to the far device.
// - Input bits set by far device latch; new set bit interrupts when enabled.
// - Host write to input register clears each bit written as one.
// - Loading the output register raises data ready for the loaded bytes.
// - far_took_output sets output flag and, if enabled, requests a host interrupt.
// - Output interrupt enable is status bit 14; writing 040000 octal sets it.
// - Acknowledged output interrupt clears the output interrupt enable.
// - Interrupts use bus level 4 by default, selectable by parameter.
// - Low data ready rises on a low byte or full word load.
// - High data ready rises on a high byte or full word load.
// - system_init_out is driven during power up, power down and software init.
`ifndef PWH_REGS_VH
`define PWH_REGS_VH

// ****************************************
// Register addresses
// ****************************************
`define PWH_ADDR_STATUS   3'h0
`define PWH_ADDR_INPUT    3'h1
`define PWH_ADDR_OUTPUT   3'h2
`define PWH_ADDR_OUT_LO   3'h3
`define PWH_ADDR_OUT_HI   3'h4

// ****************************************
// Status fields and output byte lanes
// ****************************************
`define PWH_BIT_IN_IE     6
`define PWH_BIT_IN_FLAG   7
`define PWH_BIT_OUT_IE    14
`define PWH_BIT_OUT_FLAG  15
`define PWH_LO_MSB        7
`define PWH_LO_LSB        0
`define PWH_HI_MSB        15
`define PWH_HI_LSB        8

// ****************************************
// Reset values and vectors
// ****************************************
`define PWH_WORD_ZERO     16'h0000
`define PWH_LEVEL_DEFAULT 3'h4
`define PWH_VEC_INPUT     1'b0
`define PWH_VEC_OUTPUT    1'b1

`endif

/* verilog/pwh_irq_ctl.v */
// Interrupt request holder for the parallel word port
// Assumes a one-cycle acknowledge pulse from the host bus while a request stands
`timescale 1ns/1ps
`include "pwh_regs.vh"

module pwh_irq_ctl (
	input  wire i_mclk,
	input  wire i_rst_n,
	input  wire i_init,
	input  wire i_in_event,
	input  wire i_out_event,
	input  wire i_ack,
	output wire o_req,
	output wire o_vec,
	output wire o_in_ack,
	output wire o_out_ack
);

	localparam ST_IDLE = 1'b0;
	localparam ST_REQ  = 1'b1;

	reg state_reg;
	reg state_next;
	reg vec_reg;
	reg vec_next;
	reg in_pend_reg;
	reg out_pend_reg;
	wire served;

	assign served    = (state_reg == ST_REQ) && i_ack;
	assign o_req     = (state_reg == ST_REQ);
	assign o_vec     = vec_reg;
	assign o_in_ack  = served && (vec_reg == `PWH_VEC_INPUT);
	assign o_out_ack = served && (vec_reg == `PWH_VEC_OUTPUT);

	// ****************************************
	// Pending requests
	// ****************************************
	always @(posedge i_mclk) begin
		if (!i_rst_n || i_init) begin
			in_pend_reg  <= 1'b0;
			out_pend_reg <= 1'b0;
		end else begin
			in_pend_reg  <= i_in_event | (in_pend_reg & ~o_in_ack);
			out_pend_reg <= i_out_event | (out_pend_reg & ~o_out_ack);
		end
	end

	// ****************************************
	// Request sequencer
	// ****************************************
	always @* begin
		state_next = state_reg;
		vec_next   = vec_reg;
		case (state_reg)
			ST_IDLE: begin
				if (in_pend_reg) begin
					state_next = ST_REQ;
					vec_next   = `PWH_VEC_INPUT;
				end else if (out_pend_reg) begin
					state_next = ST_REQ;
					vec_next   = `PWH_VEC_OUTPUT;
				end
			end
			ST_REQ: begin
				if (i_ack) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_mclk) begin
		if (!i_rst_n || i_init) begin
			state_reg <= ST_IDLE;
			vec_reg   <= `PWH_VEC_INPUT;
		end else begin
			state_reg <= state_next;
			vec_reg   <= vec_next;
		end
	end

endmodule // pwh_irq_ctl

/* verilog/pwh_port.v */
// Parallel word input/output port with handshake lines and vectored interrupts
// Assumes all inputs synchronous to i_mclk and a single-cycle register strobe master
`timescale 1ns/1ps
`include "pwh_regs.vh"

module pwh_port #(
	parameter [2:0] LEVEL = `PWH_LEVEL_DEFAULT
) (
	input  wire        i_mclk,
	input  wire        i_rst_n,
	input  wire        i_sys_init,
	input  wire [2:0]  i_addr,
	input  wire [15:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [15:0] o_rdata,
	output wire        o_irq_req,
	output wire        o_irq_vec,
	output wire [2:0]  o_irq_level,
	input  wire        i_irq_ack,
	input  wire [15:0] i_input_lines,
	input  wire        i_far_data_ready,
	output reg         o_host_took_input,
	output reg  [15:0] o_output_lines,
	output reg         o_low_ready,
	output reg         o_high_ready,
	input  wire        i_far_took_output,
	output reg         o_system_init_out
);

	reg  [15:0] input_reg;
	reg         in_ie_reg;
	reg         out_ie_reg;
	reg         in_flag_reg;
	reg         out_flag_reg;
	reg         rdy_prev_reg;
	reg         acc_prev_reg;
	wire        init_any;
	wire        rdy_edge;
	wire        acc_edge;
	wire        new_bits;
	wire        wr_status;
	wire        wr_input;
	wire        ld_lo;
	wire        ld_hi;
	wire        in_event;
	wire        out_event;
	wire        in_ack;
	wire        out_ack;
	wire [15:0] status_word;

	function sel;
		input [2:0] addr;
		input [2:0] target;
		input       strobe;
		begin
			sel = strobe && (addr == target);
		end
	endfunction

	assign init_any  = i_sys_init;
	assign rdy_edge  = i_far_data_ready & ~rdy_prev_reg;
	assign acc_edge  = i_far_took_output & ~acc_prev_reg;
	assign new_bits  = |(i_input_lines & ~input_reg);
	assign wr_status = sel(i_addr, `PWH_ADDR_STATUS, i_wr);
	assign wr_input  = sel(i_addr, `PWH_ADDR_INPUT, i_wr);
	assign ld_lo     = sel(i_addr, `PWH_ADDR_OUTPUT, i_wr) | sel(i_addr, `PWH_ADDR_OUT_LO, i_wr);
	assign ld_hi     = sel(i_addr, `PWH_ADDR_OUTPUT, i_wr) | sel(i_addr, `PWH_ADDR_OUT_HI, i_wr);
	assign in_event  = in_ie_reg & (rdy_edge | new_bits);
	assign out_event = out_ie_reg & acc_edge;
	assign o_irq_level = LEVEL;

	// ****************************************
	// Interrupt holder
	// ****************************************
	pwh_irq_ctl u_irq (
		.i_mclk      (i_mclk),
		.i_rst_n     (i_rst_n),
		.i_init      (init_any),
		.i_in_event  (in_event),
		.i_out_event (out_event),
		.i_ack       (i_irq_ack),
		.o_req       (o_irq_req),
		.o_vec       (o_irq_vec),
		.o_in_ack    (in_ack),
		.o_out_ack   (out_ack)
	);

	// ****************************************
	// Edge history and init output
	// ****************************************
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rdy_prev_reg      <= 1'b0;
			acc_prev_reg      <= 1'b0;
			o_system_init_out <= 1'b1;
		end else begin
			rdy_prev_reg      <= i_far_data_ready;
			acc_prev_reg      <= i_far_took_output;
			o_system_init_out <= i_sys_init;
		end
	end

	// ****************************************
	// Status register
	// ****************************************
	always @(posedge i_mclk) begin
		if (!i_rst_n || init_any) begin
			in_ie_reg    <= 1'b0;
			out_ie_reg   <= 1'b0;
			in_flag_reg  <= 1'b0;
			out_flag_reg <= 1'b0;
		end else begin
			if (wr_status) begin
				in_ie_reg  <= i_wdata[`PWH_BIT_IN_IE];
				out_ie_reg <= i_wdata[`PWH_BIT_OUT_IE];
			end else begin
				if (in_ack) begin
					in_ie_reg <= 1'b0;
				end
				if (out_ack) begin
					out_ie_reg <= 1'b0;
				end
			end
			if (rdy_edge) begin
				in_flag_reg <= 1'b1;
			end else if (wr_status) begin
				in_flag_reg <= 1'b0;
			end
			if (acc_edge) begin
				out_flag_reg <= 1'b1;
			end else if (ld_lo | ld_hi) begin
				out_flag_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Input register
	// ****************************************
	always @(posedge i_mclk) begin
		if (!i_rst_n || init_any) begin
			input_reg         <= `PWH_WORD_ZERO;
			o_host_took_input <= 1'b0;
		end else begin
			if (wr_input) begin
				input_reg <= (input_reg & ~i_wdata) | i_input_lines;
			end else begin
				input_reg <= input_reg | i_input_lines;
			end
			o_host_took_input <= sel(i_addr, `PWH_ADDR_INPUT, i_rd);
		end
	end

	// ****************************************
	// Output register and data ready
	// ****************************************
	always @(posedge i_mclk) begin
		if (!i_rst_n || init_any) begin
			o_output_lines <= `PWH_WORD_ZERO;
			o_low_ready    <= 1'b0;
			o_high_ready   <= 1'b0;
		end else begin
			if (ld_lo) begin
				o_output_lines[`PWH_LO_MSB:`PWH_LO_LSB] <= i_wdata[`PWH_LO_MSB:`PWH_LO_LSB];
			end
			if (ld_hi) begin
				o_output_lines[`PWH_HI_MSB:`PWH_HI_LSB] <= i_wdata[`PWH_HI_MSB:`PWH_HI_LSB];
			end
			if (ld_lo) begin
				o_low_ready <= 1'b1;
			end else if (acc_edge) begin
				o_low_ready <= 1'b0;
			end
			if (ld_hi) begin
				o_high_ready <= 1'b1;
			end else if (acc_edge) begin
				o_high_ready <= 1'b0;
			end
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	assign status_word = {out_flag_reg, out_ie_reg, 6'h00, in_flag_reg, in_ie_reg, 6'h00};

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_rdata <= `PWH_WORD_ZERO;
		end else if (i_rd) begin
			case (i_addr)
				`PWH_ADDR_STATUS: o_rdata <= status_word;
				`PWH_ADDR_INPUT:  o_rdata <= input_reg;
				`PWH_ADDR_OUTPUT: o_rdata <= o_output_lines;
				default:          o_rdata <= `PWH_WORD_ZERO;
			endcase
		end else begin
			o_rdata <= `PWH_WORD_ZERO;
		end
	end

endmodule // pwh_port

/* dv/pwh_port_properties.sv */
// Pin checker of the parallel word port
// Bound into pwh_port, sees its ports only
`timescale 1ns/1ps
module pwh_port_properties #(parameter [2:0] LEVEL = 3'h4) (
	input wire       i_mclk,
	input wire       i_rst_n,
	input wire       i_sys_init,
	input wire [2:0] i_addr,
	input wire       i_wr,
	input wire       i_rd,
	input wire       i_irq_ack,
	input wire       o_irq_req,
	input wire [2:0] o_irq_level,
	input wire       o_host_took_input,
	input wire       o_low_ready,
	input wire       o_high_ready,
	input wire       o_system_init_out
);
	// ****
	// Properties
	// ****
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	chk_took_pulse: assert property (i_rd && i_addr == 3'h1 |=> o_host_took_input) else $error("took");
	chk_low_load: assert property (i_wr && (i_addr == 3'h2 || i_addr == 3'h3) |=> o_low_ready) else $error("lo");
	chk_high_load: assert property (i_wr && (i_addr == 3'h2 || i_addr == 3'h4) |=> o_high_ready) else $error("hi");
	chk_level_fixed: assert property (o_irq_level == LEVEL) else $error("lvl");
	chk_req_holds: assert property (o_irq_req && !i_irq_ack && !i_sys_init |=> o_irq_req) else $error("hold");
	chk_ack_drops: assert property (o_irq_req && i_irq_ack |=> !o_irq_req) else $error("ack");
	chk_init_out: assert property (i_sys_init |=> o_system_init_out) else $error("init");
	chk_init_quiet: assert property (i_sys_init |=> !o_irq_req) else $error("quiet");
endmodule // pwh_port_properties
bind pwh_port pwh_port_properties #(.LEVEL(LEVEL)) pwh_port_properties_i (.i_mclk, .i_rst_n, .i_sys_init, .i_addr,
	.i_wr, .i_rd, .i_irq_ack, .o_irq_req, .o_irq_level, .o_host_took_input, .o_low_ready, .o_high_ready,
	.o_system_init_out);

/* dv/pwh_far_model.sv */
// Far device model on the handshake lines
// Bench calls send; output loads answered i_delay+1 cycles after data ready rises
`timescale 1ns/1ps
module pwh_far_model (
	input  wire         i_mclk,
	input  wire  [3:0]  i_delay,
	input  wire         i_took_in,
	input  wire  [15:0] i_out,
	input  wire         i_rdy_lo,
	input  wire         i_rdy_hi,
	output logic [15:0] o_lines = 16'h0000,
	output logic        o_ready = 1'b0,
	output logic        o_took = 1'b0,
	output logic [15:0] o_seen
);
	logic [3:0] cnt = 4'h0;
	// ****
	// Behaviour
	// ****
	task send(input logic [15:0] d, input logic r);
		@(posedge i_mclk);
		o_lines <= d;
		@(posedge i_mclk);
		o_ready <= r;
	endtask
	always @(posedge i_mclk) begin
		if (i_took_in) begin
			o_lines <= 16'h0000;
			o_ready <= 1'b0;
		end
		if (o_took) begin
			if (!i_rdy_lo && !i_rdy_hi)
				o_took <= 1'b0;
		end else if (i_rdy_lo || i_rdy_hi) begin
			cnt <= cnt + 4'h1;
			if (cnt == i_delay) begin
				o_seen <= i_out;
				o_took <= 1'b1;
				cnt <= 4'h0;
			end
		end
	end
endmodule // pwh_far_model

/* dv/test_pwh_port.sv */
// Self-checking bench of the parallel word port
// Far model on the pins; bench drives register port, ack and init
`timescale 1ns/1ps
module test_pwh_port;
	logic        i_mclk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_sys_init = 1'b0;
	logic [2:0]  i_addr = 3'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        i_irq_ack = 1'b0;
	logic [3:0]  delay = 4'h3;
	wire  [15:0] o_rdata, o_output_lines, lines, seen;
	wire  [2:0]  o_irq_level;
	wire         o_irq_req, o_irq_vec, o_host_took_input, o_low_ready, o_high_ready, rdy, took, o_system_init_out;
	int          err_total = 0;
	int          compares = 0;
	int          cyc = 0;
	// ****
	// Design, model, tasks
	// ****
	pwh_port pwh_port_i (.i_mclk, .i_rst_n, .i_sys_init, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq_req,
		.o_irq_vec, .o_irq_level, .i_irq_ack, .i_input_lines(lines), .i_far_data_ready(rdy), .o_host_took_input,
		.o_output_lines, .o_low_ready, .o_high_ready, .i_far_took_output(took), .o_system_init_out);
	pwh_far_model pwh_far_model_i (.i_mclk, .i_delay(delay), .i_took_in(o_host_took_input), .i_out(o_output_lines),
		.i_rdy_lo(o_low_ready), .i_rdy_hi(o_high_ready), .o_lines(lines), .o_ready(rdy), .o_took(took), .o_seen(seen));
	always #5 i_mclk = ~i_mclk;
	task chk(input string n, input logic [15:0] e, g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task end_sim;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 chk("rdata", e, o_rdata);
	endtask
	task wreq(input logic v);
		int n;
		n = 0;
		while (o_irq_req !== 1'b1 && n < 20) begin
			@(posedge i_mclk);
			#1 n++;
		end
		chk("req", 1'b1, o_irq_req);
		chk("vec", v, o_irq_vec);
	endtask
	task ack;
		@(posedge i_mclk);
		i_irq_ack <= 1'b1;
		@(posedge i_mclk);
		i_irq_ack <= 1'b0;
		#1 chk("req", 1'b0, o_irq_req);
	endtask
	task t_in_ctrl;
		pwh_far_model_i.send(16'h00a5, 1'b1);
		repeat (3) @(posedge i_mclk);
		#1 chk("req", 1'b0, o_irq_req);
		chk("init", 1'b0, o_system_init_out);
		rd(3'h0, 16'h0080);
		rd(3'h1, 16'h00a5);
		chk("took", 1'b1, o_host_took_input);
		rd(3'h5, 16'h0000);
		chk("took", 1'b0, o_host_took_input);
		wr(3'h1, 16'hffff);
		wr(3'h0, 16'h0040);
		rd(3'h0, 16'h0040);
		pwh_far_model_i.send(16'h005a, 1'b1);
		wreq(1'b0);
		rd(3'h0, 16'h00c0);
		ack;
		rd(3'h0, 16'h0080);
		rd(3'h1, 16'h005a);
		wr(3'h1, 16'hffff);
	endtask
	task t_in_bits;
		wr(3'h0, 16'h0040);
		pwh_far_model_i.send(16'h0300, 1'b0);
		wreq(1'b0);
		ack;
		rd(3'h1, 16'h0300);
		wr(3'h1, 16'h0100);
		rd(3'h1, 16'h0200);
		wr(3'h1, 16'hffff);
		rd(3'h1, 16'h0000);
	endtask
	task t_out;
		wr(3'h0, 16'h4000);
		wr(3'h2, 16'hc35a);
		chk("lo", 1'b1, o_low_ready);
		chk("hi", 1'b1, o_high_ready);
		chk("out", 16'hc35a, o_output_lines);
		wreq(1'b1);
		chk("seen", 16'hc35a, seen);
		rd(3'h0, 16'hc000);
		ack;
		rd(3'h0, 16'h8000);
		wr(3'h3, 16'h0011);
		chk("lo", 1'b1, o_low_ready);
		chk("hi", 1'b0, o_high_ready);
		chk("out", 16'hc311, o_output_lines);
		repeat (8) @(posedge i_mclk);
		#1 chk("req", 1'b0, o_irq_req);
		wr(3'h4, 16'h2200);
		chk("hi", 1'b1, o_high_ready);
		chk("lo", 1'b0, o_low_ready);
		chk("out", 16'h2211, o_output_lines);
		repeat (8) @(posedge i_mclk);
	endtask
	task t_init;
		wr(3'h0, 16'h0040);
		pwh_far_model_i.send(16'h0000, 1'b1);
		wreq(1'b0);
		rd(3'h1, 16'h0000);
		@(posedge i_mclk);
		i_sys_init <= 1'b1;
		@(posedge i_mclk);
		i_sys_init <= 1'b0;
		#1 chk("init", 1'b1, o_system_init_out);
		chk("req", 1'b0, o_irq_req);
		rd(3'h0, 16'h0000);
	endtask
	initial begin
		repeat (12) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		#1 chk("init", 1'b1, o_system_init_out);
		chk("lvl", 16'h0004, o_irq_level);
		t_in_ctrl;
		t_in_bits;
		t_out;
		t_init;
		end_sim;
	end
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_total++;
			end_sim;
		end
	end
endmodule // test_pwh_port
